// File: rtl/ctm_defs.vh
// constants for the transceiver mode control block
`ifndef CTM_DEFS_VH
`define CTM_DEFS_VH
`define CTM_MODE_W 4
`define CTM_MODE_NORMAL 4'h1
`define CTM_MODE_RXONLY 4'h2
`define CTM_MODE_STANDBY 4'h4
`define CTM_MODE_PWRDN 4'h8
`define CTM_BIAS_W 2
`define CTM_BIAS_FLOAT 2'h0
`define CTM_BIAS_GND 2'h1
`define CTM_BIAS_HALF 2'h2
`define CTM_CLK_MHZ 125
`define CTM_TXTO_US 4000
`define CTM_TXTO_CYC (`CTM_TXTO_US * `CTM_CLK_MHZ)
`define CTM_FILT_NS 1000
`define CTM_FILT_CYC ((`CTM_FILT_NS * `CTM_CLK_MHZ + 999) / 1000)
`define CTM_WAKE_US 1000
`define CTM_WAKE_CYC (`CTM_WAKE_US * `CTM_CLK_MHZ)
`define CTM_FIFO_W 1
`define CTM_FIFO_D 16
`endif

// File: rtl/ctm_sync.v
// two-flop synchroniser for one level
`timescale 1ns/1ps
module ctm_sync #(
   parameter RST_VAL = 1'b0
) (
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // level
   input wire d,
   output reg q
);
   reg meta_q;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // ctm_sync

// File: rtl/ctm_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module ctm_fifo #(
   parameter WIDTH = 1,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data,
   // flush
   input wire clear
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;
   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data = mem[rd_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always @(posedge clk_sys) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else if (clear) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // ctm_fifo

// File: rtl/ctm_top.v
// transceiver mode control: mode sequencing, transmit gating, wake detection
`timescale 1ns/1ps
`include "ctm_defs.vh"
module ctm_top #(
   parameter TXTO_CYC = `CTM_TXTO_CYC,
   parameter FILT_CYC = `CTM_FILT_CYC,
   parameter WAKE_CYC = `CTM_WAKE_CYC,
   parameter CNT_W = 20,
   parameter FIFO_W = `CTM_FIFO_W,
   parameter FIFO_D = `CTM_FIFO_D
) (
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // controller side
   input wire tx_data,
   input wire mode_select,
   output reg rx_data,
   // supply and temperature flags, high when faulty
   input wire io_uv,
   input wire transmitter_supply_uv,
   input wire overtemp,
   // bus side: dominant when high
   input wire bus_dominant,
   output reg bus_drive_dom,
   output reg bus_drive_oe,
   output reg [`CTM_BIAS_W-1:0] bus_bias,
   output reg bus_term_on,
   // receiver enables and status
   output reg normal_rx_on,
   output reg lowpwr_rx_on,
   output reg [`CTM_MODE_W-1:0] mode,
   output reg txto_flag,
   output reg wake_flag,
   // receive sample stream for logging
   output reg log_valid,
   input wire log_ready,
   output reg log_data
);
   localparam [`CTM_MODE_W-1:0] S_NORMAL = `CTM_MODE_NORMAL;
   localparam [`CTM_MODE_W-1:0] S_RXONLY = `CTM_MODE_RXONLY;
   localparam [`CTM_MODE_W-1:0] S_STANDBY = `CTM_MODE_STANDBY;
   localparam [`CTM_MODE_W-1:0] S_PWRDN = `CTM_MODE_PWRDN;
   // wake detector phases, one-hot
   localparam [3:0] W_IDLE = 4'h1;
   localparam [3:0] W_DOM1 = 4'h2;
   localparam [3:0] W_REC = 4'h4;
   localparam [3:0] W_DOM2 = 4'h8;

   wire txd_s;
   wire sel_s;
   wire iouv_s;
   wire vuv_s;
   wire ot_s;
   wire bus_s;

   ctm_sync #(.RST_VAL(1'b1)) u_s_txd (.clk_sys(clk_sys), .rst_n(rst_n), .d(tx_data), .q(txd_s));
   ctm_sync #(.RST_VAL(1'b1)) u_s_sel (.clk_sys(clk_sys), .rst_n(rst_n), .d(mode_select), .q(sel_s));
   ctm_sync #(.RST_VAL(1'b1)) u_s_iouv (.clk_sys(clk_sys), .rst_n(rst_n), .d(io_uv), .q(iouv_s));
   ctm_sync #(.RST_VAL(1'b1)) u_s_vuv (.clk_sys(clk_sys), .rst_n(rst_n), .d(transmitter_supply_uv), .q(vuv_s));
   ctm_sync #(.RST_VAL(1'b0)) u_s_ot (.clk_sys(clk_sys), .rst_n(rst_n), .d(overtemp), .q(ot_s));
   ctm_sync #(.RST_VAL(1'b0)) u_s_bus (.clk_sys(clk_sys), .rst_n(rst_n), .d(bus_dominant), .q(bus_s));

   reg [`CTM_MODE_W-1:0] st_q;
   reg [`CTM_MODE_W-1:0] st_d;
   reg txd_prev_q;
   reg [CNT_W-1:0] to_cnt_q;
   reg to_q;
   reg [3:0] w_q;
   reg [CNT_W-1:0] ph_cnt_q;
   reg [CNT_W-1:0] win_cnt_q;
   reg wake_q;
   reg filt_bus_q;
   reg [CNT_W-1:0] filt_cnt_q;
   reg tx_en;
   wire in_normal;
   wire in_standby;
   wire f_valid;
   wire f_ready;
   wire f_out;

   assign in_normal = (st_q == S_NORMAL);
   assign in_standby = (st_q == S_STANDBY);

   // mode sequencer
   always @* begin
      st_d = st_q;
      if (iouv_s) begin
         st_d = S_PWRDN;
      end else begin
         // only select and supply flag steer here
         case (st_q)
            S_PWRDN: begin
               if (sel_s) begin
                  st_d = S_STANDBY;
               end else if (vuv_s) begin
                  st_d = S_RXONLY;
               end else begin
                  st_d = S_NORMAL;
               end
            end
            S_NORMAL: begin
               if (sel_s) begin
                  st_d = S_STANDBY;
               end else if (vuv_s) begin
                  st_d = S_RXONLY;
               end
            end
            S_RXONLY: begin
               if (sel_s) begin
                  st_d = S_STANDBY;
               end else if (!vuv_s) begin
                  st_d = S_NORMAL;
               end
            end
            S_STANDBY: begin
               // supply ignored while select is high; low select with no supply goes to receive-only
               if (!sel_s) begin
                  st_d = vuv_s ? S_RXONLY : S_NORMAL;
               end
            end
            default: st_d = S_PWRDN;
         endcase
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= S_PWRDN;
      end else begin
         st_q <= st_d;
      end
   end

   // transmit time-out monitor, release on rising edge
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         txd_prev_q <= 1'b1;
         to_cnt_q <= {CNT_W{1'b0}};
         to_q <= 1'b0;
      end else begin
         txd_prev_q <= txd_s;
         if (!in_normal) begin
            to_cnt_q <= {CNT_W{1'b0}};
            to_q <= 1'b0;
         end else if (txd_s) begin
            to_cnt_q <= {CNT_W{1'b0}};
            if (!txd_prev_q) begin
               to_q <= 1'b0;
            end
         end else if (to_cnt_q >= TXTO_CYC[CNT_W-1:0] - 1'b1) begin
            to_q <= 1'b1;
         end else begin
            to_cnt_q <= to_cnt_q + 1'b1;
         end
      end
   end

   // overtemperature gating, transmitter only in normal
   always @* begin
      tx_en = in_normal & ~to_q & ~ot_s & ~iouv_s;
   end

   // receiver-side filter: bus level accepted after the filter time
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         filt_bus_q <= 1'b0;
         filt_cnt_q <= {CNT_W{1'b0}};
      end else if (bus_s == filt_bus_q) begin
         filt_cnt_q <= {CNT_W{1'b0}};
      end else if (filt_cnt_q >= FILT_CYC[CNT_W-1:0] - 1'b1) begin
         filt_bus_q <= bus_s;
         filt_cnt_q <= {CNT_W{1'b0}};
      end else begin
         filt_cnt_q <= filt_cnt_q + 1'b1;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         w_q <= W_IDLE;
         ph_cnt_q <= {CNT_W{1'b0}};
         win_cnt_q <= {CNT_W{1'b0}};
         wake_q <= 1'b0;
      end else if (!in_standby) begin
         w_q <= W_IDLE;
         ph_cnt_q <= {CNT_W{1'b0}};
         win_cnt_q <= {CNT_W{1'b0}};
         // wake flag drops on leaving stand-by and stays low in every other mode
         wake_q <= 1'b0;
      end else begin
         if (w_q != W_IDLE) begin
            win_cnt_q <= win_cnt_q + 1'b1;
         end
         case (w_q)
            W_IDLE: begin
               win_cnt_q <= {CNT_W{1'b0}};
               ph_cnt_q <= {CNT_W{1'b0}};
               if (bus_s) begin
                  w_q <= W_DOM1;
               end
            end
            W_DOM1, W_REC, W_DOM2: begin
               if (win_cnt_q >= WAKE_CYC[CNT_W-1:0] - 1'b1) begin
                  w_q <= W_IDLE;
               end else if (bus_s == (w_q != W_REC)) begin
                  if (ph_cnt_q >= FILT_CYC[CNT_W-1:0] - 1'b1) begin
                     if (w_q == W_DOM2) begin
                        wake_q <= 1'b1;
                        w_q <= W_IDLE;
                     end
                  end else begin
                     ph_cnt_q <= ph_cnt_q + 1'b1;
                  end
               end else if (ph_cnt_q >= FILT_CYC[CNT_W-1:0] - 1'b1) begin
                  ph_cnt_q <= {CNT_W{1'b0}};
                  w_q <= (w_q == W_DOM1) ? W_REC : W_DOM2;
               end else if (w_q == W_DOM1) begin
                  w_q <= W_IDLE;
               end else begin
                  ph_cnt_q <= {CNT_W{1'b0}};
               end
            end
            default: w_q <= W_IDLE;
         endcase
      end
   end

   // registered outputs
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_data <= 1'b1;
         bus_drive_dom <= 1'b0;
         bus_drive_oe <= 1'b0;
         bus_bias <= `CTM_BIAS_FLOAT;
         bus_term_on <= 1'b0;
         normal_rx_on <= 1'b0;
         lowpwr_rx_on <= 1'b0;
         mode <= S_PWRDN;
         txto_flag <= 1'b0;
         wake_flag <= 1'b0;
      end else begin
         mode <= st_q;
         txto_flag <= to_q;
         wake_flag <= wake_q;
         // low transmit data drives dominant, blocked otherwise
         bus_drive_oe <= tx_en;
         bus_drive_dom <= tx_en & ~txd_s;
         bus_term_on <= ~iouv_s & (st_q != S_PWRDN);
         normal_rx_on <= (st_q == S_NORMAL) | (st_q == S_RXONLY);
         lowpwr_rx_on <= in_standby;
         case (st_q)
            S_NORMAL: bus_bias <= `CTM_BIAS_HALF;
            S_RXONLY: bus_bias <= `CTM_BIAS_GND;
            S_STANDBY: bus_bias <= `CTM_BIAS_GND;
            default: bus_bias <= `CTM_BIAS_FLOAT;
         endcase
         if ((st_q == S_NORMAL) | (st_q == S_RXONLY)) begin
            rx_data <= ~bus_s;
         // follow filtered bus after wake, high before
         end else if (in_standby & wake_q) begin
            rx_data <= ~filt_bus_q;
         end else begin
            rx_data <= 1'b1;
         end
      end
   end

   // receive samples buffered for an optional logger; full fifo drops samples
   ctm_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D), .AW(4)) u_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .in_valid(normal_rx_on),
      .in_ready(f_ready),
      .in_data(rx_data),
      .out_valid(f_valid),
      .out_ready(~log_valid),
      .out_data(f_out),
      .clear(st_q == S_PWRDN)
   );

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         log_valid <= 1'b0;
         log_data <= 1'b0;
      end else if (log_valid) begin
         if (log_ready) begin
            log_valid <= 1'b0;
         end
      end else if (f_valid) begin
         log_valid <= 1'b1;
         log_data <= f_out;
      end
   end
endmodule // ctm_top

// File: tb/ctm_chk.sv
// assertion checker bound to the transceiver mode control top
`timescale 1ns/1ps
`include "ctm_defs.vh"
module ctm_chk (
   // clock and reset
   input logic clk_sys,
   input logic rst_n,
   // controller side
   input logic tx_data,
   input logic mode_select,
   input logic rx_data,
   // supply and temperature flags
   input logic io_uv,
   input logic transmitter_supply_uv,
   input logic overtemp,
   // bus side
   input logic bus_dominant,
   input logic bus_drive_dom,
   input logic bus_drive_oe,
   input logic [`CTM_BIAS_W-1:0] bus_bias,
   input logic bus_term_on,
   // status
   input logic normal_rx_on,
   input logic lowpwr_rx_on,
   input logic [`CTM_MODE_W-1:0] mode,
   input logic txto_flag,
   input logic wake_flag
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_tx_low;
      (!tx_data && !mode_select && mode == `CTM_MODE_NORMAL && !txto_flag && !overtemp && !io_uv
         && !transmitter_supply_uv)[*4];
   endsequence
   sequence s_bus_dom;
      (bus_dominant && normal_rx_on)[*4];
   endsequence
   property p_tx_dom;
      s_tx_low |-> bus_drive_oe && bus_drive_dom;
   endproperty
   a_tx_dom: assert property (p_tx_dom) else $error("low transmit data not driven dominant");
   property p_rx_dom;
      s_bus_dom |-> !rx_data;
   endproperty
   a_rx_dom: assert property (p_rx_dom) else $error("dominant bus not reported low");
   property p_stby_rx;
      (mode == `CTM_MODE_STANDBY && !wake_flag)[*4] |-> rx_data;
   endproperty
   a_stby_rx: assert property (p_stby_rx) else $error("receive output low before wake");
   property p_pwrdn;
      io_uv[*6] |-> mode == `CTM_MODE_PWRDN && !bus_drive_oe && !normal_rx_on && !lowpwr_rx_on
         && bus_bias == `CTM_BIAS_FLOAT && !bus_term_on;
   endproperty
   a_pwrdn: assert property (p_pwrdn) else $error("logic undervoltage left something on");
   property p_normal;
      (mode == `CTM_MODE_NORMAL)[*2] |-> normal_rx_on && !lowpwr_rx_on && bus_bias == `CTM_BIAS_HALF;
   endproperty
   a_normal: assert property (p_normal) else $error("normal mode outputs wrong");
   property p_rxonly;
      (mode == `CTM_MODE_RXONLY)[*2] |-> normal_rx_on && !lowpwr_rx_on && bus_bias == `CTM_BIAS_GND
         && !bus_drive_oe;
   endproperty
   a_rxonly: assert property (p_rxonly) else $error("receive-only outputs wrong");
   property p_stby;
      (mode == `CTM_MODE_STANDBY)[*2] |-> !normal_rx_on && lowpwr_rx_on && bus_bias == `CTM_BIAS_GND
         && !bus_drive_oe;
   endproperty
   a_stby: assert property (p_stby) else $error("stand-by outputs wrong");
   property p_sel_stby;
      (mode_select && !io_uv)[*8] |-> mode == `CTM_MODE_STANDBY;
   endproperty
   a_sel_stby: assert property (p_sel_stby) else $error("high select did not hold stand-by");
   property p_txto;
      txto_flag[*2] |-> !(bus_drive_oe && bus_drive_dom);
   endproperty
   a_txto: assert property (p_txto) else $error("transmitter driving after time-out");
endmodule // ctm_chk

bind ctm_top ctm_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .tx_data(tx_data), .mode_select(mode_select),
   .rx_data(rx_data), .io_uv(io_uv), .transmitter_supply_uv(transmitter_supply_uv), .overtemp(overtemp),
   .bus_dominant(bus_dominant), .bus_drive_dom(bus_drive_dom), .bus_drive_oe(bus_drive_oe),
   .bus_bias(bus_bias), .bus_term_on(bus_term_on), .normal_rx_on(normal_rx_on),
   .lowpwr_rx_on(lowpwr_rx_on), .mode(mode), .txto_flag(txto_flag), .wake_flag(wake_flag));

// File: tb/ctm_bus_model.sv
// bus model: dominant wins, recessive when nobody drives
`timescale 1ns/1ps
module ctm_bus_model (
   // local transmitter
   input logic drive_dom,
   input logic drive_oe,
   // other nodes
   input logic node_dom,
   // resolved bus state
   output logic bus_dominant
);
   // termination pulls to recessive when released
   assign bus_dominant = (drive_oe & drive_dom) | node_dom;
endmodule // ctm_bus_model

// File: tb/ctm_top_tb.sv
// self-checking testbench for the transceiver mode control block
`timescale 1ns/1ps
`include "ctm_defs.vh"
module ctm_top_tb;
   localparam int TXTO = 50;
   localparam int FILT = 4;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic tx_data = 1'b1;
   logic mode_select = 1'b1;
   logic io_uv = 1'b0;
   logic transmitter_supply_uv = 1'b0;
   logic overtemp = 1'b0;
   logic node_dom = 1'b0;
   logic log_ready = 1'b0;
   logic rx_data, bus_dominant, bus_drive_dom, bus_drive_oe, bus_term_on, normal_rx_on;
   logic lowpwr_rx_on, txto_flag, wake_flag, log_valid, log_data;
   logic [`CTM_BIAS_W-1:0] bus_bias;
   logic [`CTM_MODE_W-1:0] mode;
   int n_mismatch = 0;
   int comparisons = 0;
   always #4 clk_sys = ~clk_sys;
   ctm_top #(.TXTO_CYC(TXTO), .FILT_CYC(FILT), .WAKE_CYC(100)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
      .tx_data(tx_data), .mode_select(mode_select), .rx_data(rx_data), .io_uv(io_uv),
      .transmitter_supply_uv(transmitter_supply_uv), .overtemp(overtemp), .bus_dominant(bus_dominant),
      .bus_drive_dom(bus_drive_dom), .bus_drive_oe(bus_drive_oe), .bus_bias(bus_bias),
      .bus_term_on(bus_term_on), .normal_rx_on(normal_rx_on), .lowpwr_rx_on(lowpwr_rx_on), .mode(mode),
      .txto_flag(txto_flag), .wake_flag(wake_flag), .log_valid(log_valid), .log_ready(log_ready),
      .log_data(log_data));
   ctm_bus_model bus_u (.drive_dom(bus_drive_dom), .drive_oe(bus_drive_oe), .node_dom(node_dom),
      .bus_dominant(bus_dominant));
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wait_mode(input logic [3:0] m);
      for (int i = 0; i < 40 && mode !== m; i++) cyc(1);
      chk("mode", mode, m);
      if (mode !== m) tally_and_finish();
   endtask
   task automatic t_start();
      wait_mode(`CTM_MODE_STANDBY);
      chk("rx_data", rx_data, 1);
      $display("test start done");
   endtask
   task automatic t_fifo();
      int n;
      n = 0;
      @(posedge clk_sys) mode_select <= 1'b0;
      wait_mode(`CTM_MODE_NORMAL);
      cyc(24);
      chk("log_valid", log_valid, 1);
      @(posedge clk_sys) mode_select <= 1'b1;
      wait_mode(`CTM_MODE_STANDBY);
      @(posedge clk_sys) log_ready <= 1'b1;
      cyc(0);
      // each sample stands valid for one cycle before it is taken
      for (int i = 0; i < 80; i++) begin
         if (log_valid === 1'b1) begin
            n++;
            chk("log_data", log_data, 1);
         end
         cyc(1);
      end
      // fifo depth plus the output register
      chk("drained", n[7:0], `CTM_FIFO_D + 1);
      $display("test fifo done");
   endtask
   task automatic t_normal();
      @(posedge clk_sys) mode_select <= 1'b0;
      wait_mode(`CTM_MODE_NORMAL);
      @(posedge clk_sys) tx_data <= 1'b0;
      cyc(4);
      chk("drive_dom", bus_drive_dom, 1);
      cyc(4);
      chk("rx_data", rx_data, 0);
      @(posedge clk_sys) tx_data <= 1'b1;
      node_dom <= 1'b1;
      cyc(8);
      chk("drive_dom", bus_drive_dom, 0);
      chk("rx_data", rx_data, 0);
      @(posedge clk_sys) node_dom <= 1'b0;
      $display("test normal done");
   endtask
   task automatic t_txto();
      @(posedge clk_sys) tx_data <= 1'b0;
      cyc(TXTO + 8);
      chk("txto_flag", txto_flag, 1);
      chk("drive", bus_drive_oe && bus_drive_dom, 0);
      @(posedge clk_sys) tx_data <= 1'b1;
      cyc(6);
      chk("txto_flag", txto_flag, 0);
      @(posedge clk_sys) tx_data <= 1'b0;
      cyc(5);
      chk("drive_dom", bus_drive_dom, 1);
      @(posedge clk_sys) overtemp <= 1'b1;
      cyc(6);
      chk("drive", bus_drive_oe && bus_drive_dom, 0);
      @(posedge clk_sys) overtemp <= 1'b0;
      tx_data <= 1'b1;
      cyc(6);
      $display("test timeout done");
   endtask
   task automatic t_uv();
      @(posedge clk_sys) transmitter_supply_uv <= 1'b1;
      wait_mode(`CTM_MODE_RXONLY);
      @(posedge clk_sys) tx_data <= 1'b0;
      overtemp <= 1'b1;
      cyc(TXTO + 8);
      chk("drive_oe", bus_drive_oe, 0);
      chk("txto_flag", txto_flag, 0);
      chk("mode", mode, `CTM_MODE_RXONLY);
      @(posedge clk_sys) tx_data <= 1'b1;
      overtemp <= 1'b0;
      node_dom <= 1'b1;
      cyc(6);
      chk("rx_data", rx_data, 0);
      @(posedge clk_sys) node_dom <= 1'b0;
      mode_select <= 1'b1;
      wait_mode(`CTM_MODE_STANDBY);
      $display("test undervoltage done");
   endtask
   task automatic t_wake();
      cyc(10);
      chk("mode", mode, `CTM_MODE_STANDBY);
      @(posedge clk_sys) node_dom <= 1'b1;
      repeat (2) @(posedge clk_sys);
      node_dom <= 1'b0;
      cyc(8);
      chk("wake_flag", wake_flag, 0);
      chk("rx_data", rx_data, 1);
      @(posedge clk_sys) node_dom <= 1'b1;
      repeat (FILT + 3) @(posedge clk_sys);
      node_dom <= 1'b0;
      repeat (FILT + 3) @(posedge clk_sys);
      node_dom <= 1'b1;
      repeat (FILT + 3) @(posedge clk_sys);
      cyc(4);
      chk("wake_flag", wake_flag, 1);
      chk("mode", mode, `CTM_MODE_STANDBY);
      chk("rx_data", rx_data, 0);
      @(posedge clk_sys) node_dom <= 1'b0;
      cyc(FILT + 8);
      chk("rx_data", rx_data, 1);
      @(posedge clk_sys) mode_select <= 1'b0;
      wait_mode(`CTM_MODE_RXONLY);
      $display("test wake done");
   endtask
   task automatic t_pwrdn();
      @(posedge clk_sys) io_uv <= 1'b1;
      mode_select <= 1'b0;
      wait_mode(`CTM_MODE_PWRDN);
      chk("bias", bus_bias, `CTM_BIAS_FLOAT);
      chk("term_on", bus_term_on, 0);
      @(posedge clk_sys) io_uv <= 1'b0;
      wait_mode(`CTM_MODE_RXONLY);
      @(posedge clk_sys) transmitter_supply_uv <= 1'b0;
      wait_mode(`CTM_MODE_NORMAL);
      $display("test power-down done");
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_start();
      t_fifo();
      t_normal();
      t_txto();
      t_uv();
      t_wake();
      t_pwrdn();
      tally_and_finish();
   end
endmodule // ctm_top_tb
